// *** src/tptirq_pkg.sv ***
// Purpose: Constants for the pulse-train control and interrupt flag block
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes: Control register offset is locally assigned
package tptirq_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFF_CTRL = 8'h18;
   localparam logic [7:0] OFF_IRQ = 8'h1C;
   localparam logic [7:0] OFF_CLR = 8'h20;
   localparam logic [7:0] OFF_EVT = 8'h24;
   // Control register field positions
   localparam int BIT_MODE_LO = 0;
   localparam int BIT_ENABLE = 7;
   localparam int BIT_PT_SEL = 8;
   localparam int BIT_SW_SEL = 9;
   localparam int BIT_TRIG = 10;
   localparam int MODE_W = 2;
   localparam logic [1:0] MODE_PWM = 2'h0;
   // Interrupt register layout
   localparam int NFLAG = 4;
   localparam int BIT_PEND_LO = 0;
   localparam int BIT_IEN_LO = 4;
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [3:0] RST_FLAGS = 4'h0;
   typedef enum logic [1:0] {
      PT_IDLE = 2'b00,
      PT_RUN = 2'b01
   } tptirq_state_t;
endpackage

// *** src/tptirq_sync.sv ***
// Purpose: Two-flop synchroniser with edge detect after the second stage
// Assumes: Single clock domain on the output side
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module tptirq_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Pin in, synchronised level and edge out
   input wire logic pinAsync,
   output logic level,
   output logic edgeSeen
);
   logic stage1;
   logic stage2;
   logic last;
   // Two flip-flops then a history flop for the edge detector
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         last <= 1'b0;
      end else begin
         stage1 <= pinAsync;
         stage2 <= stage1;
         last <= stage2;
      end
   end
   assign level = stage2;
   assign edgeSeen = stage2 ^ last; // Any transition
endmodule // tptirq_sync

// *** src/tptirq_irq.sv ***
// Purpose: Four sticky pending flags, enables and one interrupt level
// Assumes: Set events are one-cycle pulses from this clock
// Notes: A set in the clear cycle wins
`timescale 1ns/1ps
module tptirq_irq #(
   parameter int N = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic unitEnable,
   input wire logic [N-1:0] setPulse,
   input wire logic [N-1:0] clrPulse,
   input wire logic [N-1:0] enables,
   // Status
   output logic [N-1:0] pending,
   output logic irq
);
   // Sticky flags, held clear while the unit is off
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pending <= '0;
      end else if (!unitEnable) begin
         pending <= '0; // R14
      end else begin
         pending <= (pending & ~clrPulse) | setPulse; // R12
      end
   end
   // Registered interrupt level
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((pending & ~clrPulse) | setPulse) & enables & {N{unitEnable}}); // R15
      end
   end
endmodule // tptirq_irq

// *** src/tptirq_top.sv ***
// What this block does
// [R1] Bit 8 with mode 00b selects pulse-train mode
// [R2] Bit 8 ignored unless mode is 00b
// [R3] Software select set: start only by trigger bit
// [R4] Software select clear: start on pin-B transition
// [R5] Software select ignored outside pulse-train mode
// [R6] Writing trigger bit one starts the train
// [R7] Second counter underflow clears trigger bit
// [R8] Trigger writes ignored when software select clear
// [R9] Hardware sets trigger bit on external start
// [R10] Four read-only pending flags, bits 0-3
// [R11] Bits 4-7 are interrupt enables, reset 0
// [R12] Write one to clear register clears flags
// [R13] Software writes reserved fields as zero
// [R14] Unit disabled clears pending, blocks writes; code still takes every register write while off
// [R15] Interrupt when flag and enable both set
//
// Purpose: Pulse-train trigger control and timer interrupt flags
// Assumes: Register port with read data one cycle after strobe
// Notes: Pending flags set by event inputs from the timer core
`timescale 1ns/1ps
module tptirq_top
   import tptirq_pkg::*;
#(
   parameter int NF = tptirq_pkg::NFLAG
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [tptirq_pkg::ADDR_W-1:0] regAddr,
   input wire logic [tptirq_pkg::DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [tptirq_pkg::DATA_W-1:0] regRdata,
   // Timer core links
   input wire logic inputBPin,
   input wire logic secondCounterUnderflow,
   input wire logic [NF-1:0] flagEvent,
   // Outputs to timer core and system
   output logic pulseTrainMode,
   output logic pulseTrainRun,
   output logic timerUnitEnable,
   output logic [1:0] operatingMode,
   output logic timerIrq
);
   import tptirq_pkg::*;

   logic [31:0] ctrl;
   logic [NF-1:0] irqEnable;
   logic [NF-1:0] pending;
   logic irqLevel;
   logic pinLevel;
   logic pinEdge;
   logic trigBit;
   logic ptMode;
   logic wrCtrl;
   logic wrIrq;
   logic wrClr;
   logic swStart;
   logic hwStart;
   logic next_trig;
   logic [NF-1:0] clrPulse;
   tptirq_state_t state;

   // Write decode
   assign wrCtrl = regWrite && (regAddr == OFF_CTRL);
   assign wrIrq = regWrite && (regAddr == OFF_IRQ);
   assign wrClr = regWrite && (regAddr == OFF_CLR);

   // Mode 1a only when the select bit is set and the field is 00b
   assign ptMode = ctrl[BIT_PT_SEL] && (ctrl[BIT_MODE_LO +: MODE_W] == MODE_PWM); // R1 R2

   // Pin B synchroniser
   tptirq_sync u_sync (
      .clk(clk),
      .reset(reset),
      .pinAsync(inputBPin),
      .level(pinLevel),
      .edgeSeen(pinEdge)
   );

   // Start sources, select bit only counts in mode 1a
   assign swStart = ptMode && ctrl[BIT_SW_SEL] && wrCtrl && regWdata[BIT_TRIG]; // R3 R5 R6
   assign hwStart = ptMode && !ctrl[BIT_SW_SEL] && pinEdge && ctrl[BIT_ENABLE]; // R4 R9

   // Trigger bit next value: underflow ends the train
   always_comb begin
      next_trig = trigBit;
      if (!ptMode) begin
         if (wrCtrl) begin
            next_trig = regWdata[BIT_TRIG];
         end
      end else if (ctrl[BIT_SW_SEL]) begin
         if (wrCtrl) begin
            next_trig = regWdata[BIT_TRIG]; // R6
         end
      end
      if (hwStart) begin
         next_trig = 1'b1; // R9
      end
      if (secondCounterUnderflow && trigBit) begin
         next_trig = 1'b0; // R7
      end
      if (swStart || (hwStart && !trigBit)) begin
         next_trig = 1'b1;
      end
   end

   // Control register; trigger writes ignored in external mode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl <= RST_CTRL;
      end else if (wrCtrl) begin
         ctrl <= {21'h0, 1'b0, regWdata[9:0]}; // R13
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         trigBit <= 1'b0;
      end else begin
         trigBit <= next_trig; // R8
      end
   end

   // Train state follows the trigger bit
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= PT_IDLE;
      end else begin
         unique case (state)
            PT_IDLE: begin
               if (ptMode && next_trig && !trigBit) begin
                  state <= PT_RUN;
               end
            end
            PT_RUN: begin
               if (!next_trig || !ptMode) begin
                  state <= PT_IDLE; // R7
               end
            end
         endcase
      end
   end

   // Interrupt enables
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqEnable <= RST_FLAGS;
      end else if (wrIrq) begin
         irqEnable <= regWdata[BIT_IEN_LO +: NF]; // R11
      end
   end

   assign clrPulse = wrClr ? regWdata[NF-1:0] : '0; // R12

   // Pending flags and interrupt level
   tptirq_irq #(.N(NF)) u_irq (
      .clk(clk),
      .reset(reset),
      .unitEnable(ctrl[BIT_ENABLE]),
      .setPulse(flagEvent),
      .clrPulse(clrPulse),
      .enables(irqEnable),
      .pending(pending),
      .irq(irqLevel)
   );

   // Read data, one cycle after the strobe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regRdata <= '0;
      end else if (regRead) begin
         unique case (regAddr)
            OFF_CTRL: regRdata <= {ctrl[31:11], trigBit, ctrl[9:0]};
            OFF_IRQ: regRdata <= {24'h0, irqEnable, pending}; // R10
            OFF_EVT: regRdata <= {29'h0, pinLevel, state == PT_RUN, ptMode};
            default: regRdata <= '0;
         endcase
      end else begin
         regRdata <= '0;
      end
   end

   // Registered outputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pulseTrainMode <= 1'b0;
         pulseTrainRun <= 1'b0;
         timerUnitEnable <= 1'b0;
         operatingMode <= 2'h0;
      end else begin
         pulseTrainMode <= ptMode;
         pulseTrainRun <= ptMode && next_trig;
         timerUnitEnable <= ctrl[BIT_ENABLE];
         operatingMode <= ctrl[BIT_MODE_LO +: MODE_W];
      end
   end
   assign timerIrq = irqLevel;

   // Checks
   a_mode_gate: assert property (@(posedge clk) disable iff (reset)
      (ctrl[1:0] != MODE_PWM) |=> !pulseTrainMode) else $error("mode gate broken"); // R2
   a_under_clear: assert property (@(posedge clk) disable iff (reset)
      (trigBit && secondCounterUnderflow && !swStart && !hwStart) |=> !trigBit)
      else $error("underflow did not clear trigger"); // R7
   a_ext_write: assert property (@(posedge clk) disable iff (reset)
      (ptMode && !ctrl[9] && wrCtrl && regWdata[10] && !trigBit && !hwStart) |=> !trigBit)
      else $error("trigger write not ignored"); // R8
   a_pin_start: assert property (@(posedge clk) disable iff (reset)
      hwStart |=> trigBit) else $error("pin start missed"); // R9
   a_clear_sel: assert property (@(posedge clk) disable iff (reset)
      (wrClr && regWdata[0] && !flagEvent[0]) |=> !pending[0]) else $error("flag not cleared"); // R12
   a_flag_keep: assert property (@(posedge clk) disable iff (reset)
      (pending[1] && !(wrClr && regWdata[1]) && ctrl[7]) |=> pending[1])
      else $error("flag lost"); // R12
   a_off_clear: assert property (@(posedge clk) disable iff (reset)
      !ctrl[7] |=> pending == '0) else $error("pending kept while off"); // R14
   a_irq_level: assert property (@(posedge clk) disable iff (reset)
      ##1 timerIrq == |($past(((pending & ~clrPulse) | flagEvent) & irqEnable) & {NF{$past(ctrl[7])}}))
      else $error("irq level wrong"); // R15
   a_read_lat: assert property (@(posedge clk) disable iff (reset)
      (regRead && regAddr == OFF_IRQ) |=> regRdata[7:4] == $past(irqEnable))
      else $error("read data wrong"); // R11
   c_sw_start: cover property (@(posedge clk) swStart);
   c_hw_start: cover property (@(posedge clk) hwStart);
   c_train_end: cover property (@(posedge clk) trigBit && secondCounterUnderflow);
   c_irq: cover property (@(posedge clk) timerIrq);
endmodule // tptirq_top

// *** tb/tptirq_partner.sv ***
// Purpose: Far-side model of pin B, counter underflow and flag events
// Assumes: Tasks are entered right after a rising edge
// Notes: Every change after time zero lands by non-blocking assignment
`timescale 1ns/1ps
module tptirq_partner (
   // Clock
   input wire logic clk,
   // Timer core side
   output logic pinB,
   output logic underflow,
   output logic [3:0] events
);
   // Idle levels at time zero
   initial begin
      pinB = 1'b0;
      underflow = 1'b0;
      events = 4'h0;
   end
   // Any transition on pin B is an external start
   task automatic toggle_pin();
      pinB <= ~pinB;
      @(posedge clk);
   endtask
   // One-cycle underflow marks the end of a train
   task automatic underflow_pulse();
      underflow <= 1'b1;
      @(posedge clk);
      underflow <= 1'b0;
      @(posedge clk);
   endtask
   // One-cycle pulses that raise pending flags
   task automatic event_pulse(input logic [3:0] v);
      events <= v;
      @(posedge clk);
      events <= 4'h0;
      @(posedge clk);
   endtask
endmodule // tptirq_partner

// *** tb/tb.sv ***
// Purpose: Self-checking bench for pulse-train control and interrupt flags
// Assumes: Register port answers one cycle after the read strobe
// Notes: Each scenario is its own task
`timescale 1ns/1ps
module tb;
   import tptirq_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] regAddr = 8'h00;
   logic [DATA_W-1:0] regWdata = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [DATA_W-1:0] regRdata;
   logic inputBPin, secondCounterUnderflow, pulseTrainMode, pulseTrainRun, timerUnitEnable, timerIrq;
   logic [3:0] flagEvent;
   logic [1:0] operatingMode;
   logic [31:0] rd;
   int bad_count = 0;
   int checked = 0;
   // Control bits: unit enable, train select, software select, trigger
   localparam logic [31:0] EN = 32'h0000_0080;
   localparam logic [31:0] PT = 32'h0000_0100;
   localparam logic [31:0] SW = 32'h0000_0200;
   localparam logic [31:0] TR = 32'h0000_0400;

   tptirq_top DUT (.clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .inputBPin(inputBPin),
      .secondCounterUnderflow(secondCounterUnderflow), .flagEvent(flagEvent),
      .pulseTrainMode(pulseTrainMode), .pulseTrainRun(pulseTrainRun),
      .timerUnitEnable(timerUnitEnable), .operatingMode(operatingMode), .timerIrq(timerIrq));
   tptirq_partner PM (.clk(clk), .pinB(inputBPin), .underflow(secondCounterUnderflow), .events(flagEvent));

   // Clock, 10 ns period
   always #5 clk = ~clk;

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Compare one value
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bus write, with one idle edge so strobes never collide
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      @(posedge clk);
   endtask
   // Bus read, data taken while it stands in the cycle after the strobe
   task automatic rdreg(input logic [7:0] a);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      rd = regRdata;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Bounded wait for the run level
   task automatic wait_run(input logic v);
      int i;
      for (i = 0; i < 12 && pulseTrainRun !== v; i++) @(posedge clk);
      chk("pulseTrainRun", {31'h0, v}, {31'h0, pulseTrainRun});
      if (i == 12) tally_and_finish();
   endtask

   task automatic t_reset();
      chk("outputs", 32'h0, {26'h0, timerIrq, pulseTrainRun, pulseTrainMode, timerUnitEnable, operatingMode});
      rdreg(OFF_CTRL);
      chk("ctrl", 32'h0, rd);
      rdreg(OFF_IRQ);
      chk("irq reg", 32'h0, rd);
      rdreg(8'h30);
      chk("unmapped", 32'h0, rd);
      $display("test reset done");
   endtask
   task automatic t_sw();
      wr(OFF_CTRL, EN | PT | SW);
      idle(2);
      chk("ptMode", 32'h1, {31'h0, pulseTrainMode});
      chk("unit enable", 32'h1, {31'h0, timerUnitEnable});
      PM.toggle_pin();
      idle(5);
      chk("no pin start", 32'h0, {31'h0, pulseTrainRun});
      wr(OFF_CTRL, EN | PT | SW | TR);
      wait_run(1'b1);
      rdreg(OFF_CTRL);
      chk("trig bit", 32'h1, {31'h0, rd[10]});
      rdreg(OFF_EVT);
      chk("status", 32'h7, rd);
      PM.underflow_pulse();
      wait_run(1'b0);
      $display("test software trigger done");
   endtask
   task automatic t_pin();
      wr(OFF_CTRL, EN | PT);
      wr(OFF_CTRL, EN | PT | TR);
      idle(3);
      chk("write ignored", 32'h0, {31'h0, pulseTrainRun});
      rdreg(OFF_CTRL);
      chk("trig bit", 32'h0, {31'h0, rd[10]});
      PM.toggle_pin();
      wait_run(1'b1);
      rdreg(OFF_CTRL);
      chk("trig bit", 32'h1, {31'h0, rd[10]});
      PM.underflow_pulse();
      wait_run(1'b0);
      $display("test pin trigger done");
   endtask
   task automatic t_other();
      wr(OFF_CTRL, EN | PT | 32'h1);
      idle(2);
      chk("ptMode", 32'h0, {31'h0, pulseTrainMode});
      chk("mode", 32'h1, {30'h0, operatingMode});
      wr(OFF_CTRL, EN | PT | SW | TR | 32'h1);
      PM.toggle_pin();
      idle(5);
      chk("no run", 32'h0, {31'h0, pulseTrainRun});
      $display("test other mode done");
   endtask
   task automatic t_irq();
      wr(OFF_CTRL, EN);
      PM.event_pulse(4'hF);
      rdreg(OFF_IRQ);
      chk("pending", 32'h0F, rd);
      chk("irq off", 32'h0, {31'h0, timerIrq});
      wr(OFF_IRQ, 32'h10);
      idle(1);
      chk("irq on", 32'h1, {31'h0, timerIrq});
      wr(OFF_CLR, 32'h1);
      rdreg(OFF_IRQ);
      chk("clear A", 32'h1E, rd);
      chk("irq off", 32'h0, {31'h0, timerIrq});
      rdreg(OFF_CLR);
      chk("clear reads", 32'h0, rd);
      wr(OFF_CLR, 32'h6);
      rdreg(OFF_IRQ);
      chk("clear BC", 32'h18, rd);
      wr(OFF_CTRL, 32'h0);
      PM.event_pulse(4'h1);
      rdreg(OFF_IRQ);
      chk("disabled", 32'h10, rd);
      $display("test interrupts done");
   endtask

   // Hang guard
   initial begin
      #100us;
      bad_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_sw();
      t_pin();
      t_other();
      t_irq();
      tally_and_finish();
   end
endmodule // tb
